// ---- common/pcfg_cfg.svh ----
`ifndef PCFG_CFG_SVH
`define PCFG_CFG_SVH

// ****************************************************************
// Configuration dword indices (byte offset / 4)
// ****************************************************************
`define PCFG_DW_IDENT       6'h00
`define PCFG_DW_CTRL_STAT   6'h01
`define PCFG_DW_CLASS       6'h02
`define PCFG_DW_HEADER      6'h03
`define PCFG_DW_MEM_BASE    6'h04
`define PCFG_DW_ROM_BASE    6'h0C

// ****************************************************************
// Byte offsets of the registers themselves
// ****************************************************************
`define PCFG_OFS_VENDOR     8'h00
`define PCFG_OFS_DEVICE     8'h02
`define PCFG_OFS_CONTROL    8'h04
`define PCFG_OFS_STATUS     8'h06
`define PCFG_OFS_REVISION   8'h08
`define PCFG_OFS_PROG_IF    8'h09
`define PCFG_OFS_SUBCLASS   8'h0A
`define PCFG_OFS_CLASS      8'h0B
`define PCFG_OFS_HEADER     8'h0E
`define PCFG_OFS_MEM_BASE   8'h10
`define PCFG_OFS_ROM_BASE   8'h30

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define PCFG_CTL_IO_EN      0
`define PCFG_CTL_MEM_EN     1
`define PCFG_CTL_PAL_SNOOP  5
`define PCFG_CTL_PERR_EN    6
`define PCFG_CTL_WAIT_CYC   7
`define PCFG_CTL_SERR_EN    8

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define PCFG_ST_SEL_LO      9
`define PCFG_ST_TGT_ABORT   11
`define PCFG_ST_SYS_ERR     14
`define PCFG_ST_PAR_ERR     15

// ****************************************************************
// Fixed field values
// ****************************************************************
`define PCFG_SEL_TIMING     2'h1
`define PCFG_PROG_IF_VAL    8'h00
`define PCFG_SUBCLASS_VAL   8'h00
`define PCFG_CLASS_VAL      8'h03
`define PCFG_CTRL_RST       4'h0
`define PCFG_MEMORY_WINDOW_BASE_RST      8'h00
`define PCFG_ROM_WINDOW_BASE_RST      14'h0000

`endif

// ---- common/pcfg_pkg.sv ----
package pcfg_pkg;

    // Direction of a configuration access
    typedef enum logic [0:0]
    {
        PCFG_RD = 1'b0,
        PCFG_WR = 1'b1
    } pcfg_dir_t;

    // One configuration dword
    typedef logic [31:0] pcfg_word_t;

    // Active-low byte enables of a dword
    typedef logic [3:0] pcfg_be_t;

endpackage : pcfg_pkg

// ---- src/pcfg_sticky.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Sticky flag bank, hardware set, write-one-to-clear
// ****************************************************************
module pcfg_sticky
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Events and software clears
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    // Flag state
    output logic      [WIDTH-1:0] flag_o
);

    logic [WIDTH-1:0] flag_ff;     // Held flags
    logic [WIDTH-1:0] nxt_flag;    // Next flags

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb
    begin
        nxt_flag = (flag_ff & ~clr_i) | set_i;
    end

    // Flag register, clear at reset
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            flag_ff <= '0;
        end
        else
        begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_o = flag_ff;

endmodule : pcfg_sticky

// ---- src/pcfg_target.sv ----
`timescale 1ns/1ns
`include "pcfg_cfg.svh"

// Operation
// - Vendor code fixed at offset 00h, read-only
// - Device code fixed at offset 02h, read-only
// - Registers reached only by configuration cycles
// - Control bits 15 to 10 read zero
// - Control bits 2, 4, 9 read zero
// - Special cycles ignored; control bit 3 zero
// - Control bit 7 always reads one
// - Address parity SERR needs control bits 8, 6
// - Control bit 6 gates PERR, resets zero
// - Palette snoop bit stops palette claiming
// - Control bit 1 enables memory decode
// - Control bit 0 enables I/O response
// - Status bits clear on written ones
// - Status bit 15 flags any parity error
// - Status bit 14 flags SERR assertion
// - Status bits 13, 12 read zero
// - Non-adjacent I/O enables abort, set bit 11
// - Parity error also sets status bit 11
// - Status bits 10:9 read binary 01
// - Memory base bits 31:24 writable, size zero
module pcfg_target
    import pcfg_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0101, // Arbitrary value
    parameter logic [7:0]  REV_CODE    = 8'h00     // Arbitrary value
)
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_N_I,
    // Configuration access port
    input  wire logic        CFG_REQ_I,
    input  wire pcfg_dir_t   CFG_DIR_I,
    input  wire logic [5:0]  CFG_DWORD_I,
    input  wire pcfg_be_t    CFG_BE_N_I,
    input  wire pcfg_word_t  CFG_WDATA_I,
    output logic             CFG_ACK_O,
    output pcfg_word_t       CFG_RDATA_O,
    // Error events from the bus parity checker
    input  wire logic        ADDR_PERR_I,
    input  wire logic        DATA_PERR_I,
    // I/O cycle qualifiers from the target decoder
    input  wire logic        IO_CYCLE_I,
    input  wire pcfg_be_t    IO_BE_N_I,
    input  wire logic        PAL_HIT_I,
    input  wire logic        PAL_WRITE_I,
    // Open-drain error pins
    output logic             SERR_N_O,
    output logic             SERR_OE_N_O,
    output logic             PERR_N_O,
    output logic             PERR_OE_N_O,
    // Decode controls for the rest of the device
    output logic             IO_CLAIM_O,
    output logic             IO_TGT_ABORT_O,
    output logic             PAL_UPDATE_O,
    output logic             MEM_DECODE_EN_O,
    output logic [7:0]       MEM_BASE_O,
    output logic [13:0]      ROM_BASE_O,
    output logic             ROM_EN_O
);

    // ****************************************************************
    // Access decode
    // ****************************************************************
    logic [3:0]  lane;           // Active-high byte lanes
    logic        wr_go;          // Write taken this cycle
    logic        rd_go;          // Read taken this cycle
    logic        wr_ctrl;        // Write to control/status dword
    logic        wr_memory_window_base;       // Write to memory base dword
    logic        wr_rom_window_base;       // Write to ROM base dword

    // Configuration cycles are the only way in
    assign lane     = ~CFG_BE_N_I;
    assign wr_go    = CFG_REQ_I && (CFG_DIR_I == PCFG_WR);
    assign rd_go    = CFG_REQ_I && (CFG_DIR_I == PCFG_RD);
    assign wr_ctrl  = wr_go && (CFG_DWORD_I == `PCFG_DW_CTRL_STAT);
    assign wr_memory_window_base = wr_go && (CFG_DWORD_I == `PCFG_DW_MEM_BASE);
    assign wr_rom_window_base = wr_go && (CFG_DWORD_I == `PCFG_DW_ROM_BASE);

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic io_en_ff;      // I/O response enable
    logic mem_en_ff;     // Frame-buffer decode enable
    logic snoop_ff;      // Palette snoop
    logic perr_en_ff;    // Parity error response
    logic serr_en_ff;    // System error enable

    // Low byte holds the four writable low bits
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            // All enables off until software sets them
            {perr_en_ff, snoop_ff, mem_en_ff, io_en_ff} <=
                `PCFG_CTRL_RST;
        end
        else if (wr_ctrl && lane[0])
        begin
            io_en_ff   <= CFG_WDATA_I[`PCFG_CTL_IO_EN];
            mem_en_ff  <= CFG_WDATA_I[`PCFG_CTL_MEM_EN];
            snoop_ff   <= CFG_WDATA_I[`PCFG_CTL_PAL_SNOOP];
            perr_en_ff <= CFG_WDATA_I[`PCFG_CTL_PERR_EN];
        end
    end

    // SERR enable lives in the second byte
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            serr_en_ff <= 1'b0;
        end
        else if (wr_ctrl && lane[1])
        begin
            serr_en_ff <= CFG_WDATA_I[`PCFG_CTL_SERR_EN];
        end
    end

    // Assembled control word; master-only bits are tied off
    logic [15:0] ctrl_word;
    always_comb
    begin
        ctrl_word                       = 16'h0000;
        ctrl_word[`PCFG_CTL_IO_EN]      = io_en_ff;
        ctrl_word[`PCFG_CTL_MEM_EN]     = mem_en_ff;
        ctrl_word[`PCFG_CTL_PAL_SNOOP]  = snoop_ff;
        ctrl_word[`PCFG_CTL_PERR_EN]    = perr_en_ff;
        ctrl_word[`PCFG_CTL_WAIT_CYC]   = 1'b1;
        ctrl_word[`PCFG_CTL_SERR_EN]    = serr_en_ff;
    end

    // ****************************************************************
    // Error signalling
    // ****************************************************************
    logic serr_go;       // SERR pulse request
    logic perr_go;       // PERR pulse request
    logic abort_go;      // Target abort on an I/O cycle
    logic be_adjacent;   // I/O byte enables are contiguous
    logic serr_ff;       // SERR drive
    logic perr_ff;       // PERR drive

    // Contiguous check: no gap between active lanes
    always_comb
    begin
        unique case (~IO_BE_N_I)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8,
            4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF:
                be_adjacent = 1'b1;
            default:
                be_adjacent = 1'b0;
        endcase
    end

    // Both enables needed for SERR on address parity
    assign serr_go  = ADDR_PERR_I && serr_en_ff && perr_en_ff;
    // PERR only when the response bit is set
    assign perr_go  = (ADDR_PERR_I || DATA_PERR_I) && perr_en_ff;
    // Only I/O cycles the device responds to can be aborted
    assign abort_go = IO_CYCLE_I && io_en_ff && !be_adjacent;

    // Pins driven low for one cycle per event
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            serr_ff <= 1'b0;
            perr_ff <= 1'b0;
        end
        else
        begin
            serr_ff <= serr_go;
            perr_ff <= perr_go;
        end
    end

    // Open drain: enable low only while pulling low
    assign SERR_N_O    = 1'b0;
    assign SERR_OE_N_O = ~serr_ff;
    assign PERR_N_O    = 1'b0;
    assign PERR_OE_N_O = ~perr_ff;

    // ****************************************************************
    // Status register
    // ****************************************************************
    logic [2:0]  st_set;     // Parity, system error, target abort
    logic [2:0]  st_clr;     // Software clears
    logic [2:0]  st_flag;    // Held flags
    logic [15:0] stat_word;  // Assembled status word
    logic [15:0] w1c;        // Ones written to status

    // Upper half of the dword carries the status lanes
    assign w1c = wr_ctrl ? (CFG_WDATA_I[31:16] & {{8{lane[3]}}, {8{lane[2]}}})
                         : 16'h0000;

    // Bit 11 also set by any parity error, regardless of enables
    assign st_set = { ADDR_PERR_I || DATA_PERR_I,
                      serr_go,
                      abort_go || ADDR_PERR_I || DATA_PERR_I };
    assign st_clr = { w1c[`PCFG_ST_PAR_ERR],
                      w1c[`PCFG_ST_SYS_ERR],
                      w1c[`PCFG_ST_TGT_ABORT] };

    pcfg_sticky #(.WIDTH(3)) u_stat_flags
    (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .set_i   (st_set),
        .clr_i   (st_clr),
        .flag_o  (st_flag)
    );

    // Master-only bits stay zero; select timing is constant
    always_comb
    begin
        stat_word                          = 16'h0000;
        stat_word[`PCFG_ST_PAR_ERR]        = st_flag[2];
        stat_word[`PCFG_ST_SYS_ERR]        = st_flag[1];
        stat_word[`PCFG_ST_TGT_ABORT]      = st_flag[0];
        stat_word[`PCFG_ST_SEL_LO+1 -: 2]  = `PCFG_SEL_TIMING;
    end

    // ****************************************************************
    // Window base registers
    // ****************************************************************
    logic [7:0]  memory_window_base_ff;   // Memory window base, bits 31:24
    logic [13:0] rom_window_base_ff;   // ROM window base, bits 31:18
    logic        rom_en_ff;  // ROM decode enable

    // Only the top byte is writable, which fixes a 16MB window
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            memory_window_base_ff <= `PCFG_MEMORY_WINDOW_BASE_RST;
        end
        else if (wr_memory_window_base && lane[3])
        begin
            memory_window_base_ff <= CFG_WDATA_I[31:24];
        end
    end

    // ROM base split over two lanes; size bits are not stored
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            rom_window_base_ff <= `PCFG_ROM_WINDOW_BASE_RST;
        end
        else if (wr_rom_window_base)
        begin
            if (lane[3])
            begin
                rom_window_base_ff[13:6] <= CFG_WDATA_I[31:24];
            end
            if (lane[2])
            begin
                rom_window_base_ff[5:0] <= CFG_WDATA_I[23:18];
            end
        end
    end

    // ROM decode enable in the low lane
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            rom_en_ff <= 1'b0;
        end
        else if (wr_rom_window_base && lane[0])
        begin
            rom_en_ff <= CFG_WDATA_I[0];
        end
    end

    // ****************************************************************
    // Read data and acknowledge
    // ****************************************************************
    pcfg_word_t rd_mux;      // Selected dword
    pcfg_word_t rdata_ff;    // Registered read data
    logic       ack_ff;      // One-cycle acknowledge

    // Unmapped and reserved dwords read zero
    always_comb
    begin
        unique case (CFG_DWORD_I)
            `PCFG_DW_IDENT:     rd_mux = {DEVICE_CODE, VENDOR_CODE};
            `PCFG_DW_CTRL_STAT: rd_mux = {stat_word, ctrl_word};
            `PCFG_DW_CLASS:     rd_mux = {`PCFG_CLASS_VAL,
                                          `PCFG_SUBCLASS_VAL,
                                          `PCFG_PROG_IF_VAL, REV_CODE};
            `PCFG_DW_MEM_BASE:  rd_mux = {memory_window_base_ff, 24'h000000};
            `PCFG_DW_ROM_BASE:  rd_mux = {rom_window_base_ff, 17'h00000, rom_en_ff};
            default:            rd_mux = 32'h00000000;
        endcase
    end

    // Answer every request one cycle later
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff   <= CFG_REQ_I;
            rdata_ff <= rd_go ? rd_mux : 32'h00000000;
        end
    end

    assign CFG_ACK_O   = ack_ff;
    assign CFG_RDATA_O = rdata_ff;

    // ****************************************************************
    // Decode controls
    // ****************************************************************
    // Snoop leaves palette reads and writes unclaimed but writes still land
    assign IO_CLAIM_O      = io_en_ff && !(snoop_ff && PAL_HIT_I);
    assign PAL_UPDATE_O    = io_en_ff && PAL_HIT_I && PAL_WRITE_I;
    assign IO_TGT_ABORT_O  = abort_go;
    assign MEM_DECODE_EN_O = mem_en_ff;
    assign MEM_BASE_O      = memory_window_base_ff;
    assign ROM_BASE_O      = rom_window_base_ff;
    // ROM needs the memory enable as well
    assign ROM_EN_O        = rom_en_ff && mem_en_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_ident_rd;
        rd_go && (CFG_DWORD_I == `PCFG_DW_IDENT);
    endsequence

    sequence s_addr_perr_armed;
        ADDR_PERR_I && serr_en_ff && perr_en_ff;
    endsequence

    // Control/status read, checked on the data actually returned
    sequence s_ctrl_rd;
        rd_go && (CFG_DWORD_I == `PCFG_DW_CTRL_STAT);
    endsequence

    a_ident_fixed: assert property (s_ident_rd |=>
        CFG_RDATA_O == {DEVICE_CODE, VENDOR_CODE})
        else $error("identity read wrong");
    a_ident_dev: assert property (s_ident_rd |=>
        CFG_RDATA_O[31:16] == DEVICE_CODE)
        else $error("device code read wrong");
    a_ctrl_fixed: assert property (s_ctrl_rd |=>
        CFG_RDATA_O[15:9] == 7'h00 && CFG_RDATA_O[4:2] == 3'h0)
        else $error("fixed control bits wrong");
    a_wait_one: assert property (s_ctrl_rd |=> CFG_RDATA_O[7])
        else $error("wait cycle bit not one");
    a_serr_pulse: assert property (s_addr_perr_armed |=>
        !SERR_OE_N_O ##1 stat_word[`PCFG_ST_SYS_ERR])
        else $error("SERR or bit 14 missing");
    a_serr_gated: assert property (!serr_en_ff || !perr_en_ff |=>
        SERR_OE_N_O)
        else $error("SERR without enables");
    a_perr_gate: assert property (DATA_PERR_I && !perr_en_ff |=>
        PERR_OE_N_O)
        else $error("PERR driven while disabled");
    a_snoop_claim: assert property (snoop_ff && PAL_HIT_I |->
        !IO_CLAIM_O)
        else $error("palette claimed under snoop");
    a_w1c_clear: assert property (wr_ctrl && lane[3] &&
        CFG_WDATA_I[31] && !ADDR_PERR_I && !DATA_PERR_I |=>
        !stat_word[`PCFG_ST_PAR_ERR])
        else $error("status bit not cleared");
    a_par_sticky: assert property (DATA_PERR_I |=>
        stat_word[15] && stat_word[11])
        else $error("parity flags not set");
    a_abort_flag: assert property (abort_go |=>
        stat_word[`PCFG_ST_TGT_ABORT])
        else $error("target abort not recorded");
    a_stat_fixed: assert property (s_ctrl_rd |=>
        CFG_RDATA_O[29:28] == 2'h0 && CFG_RDATA_O[26:25] == 2'h1)
        else $error("fixed status bits wrong");
    a_rsvd_zero: assert property (rd_go &&
        CFG_DWORD_I == `PCFG_DW_HEADER |=> CFG_RDATA_O == 32'h00000000)
        else $error("reserved dword not zero");
    a_io_reset: assert property ($rose(RST_N_I) |-> !io_en_ff)
        else $error("I/O enable set after reset");

endmodule : pcfg_target

// ---- tb/pcfg_host.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Host bridge model issuing configuration cycles
// ****************************************************************
module pcfg_host
    import pcfg_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Request side
    output logic            req_o,
    output pcfg_dir_t       dir_o,
    output logic [5:0]      dword_o,
    output pcfg_be_t        be_n_o,
    output pcfg_word_t      wdata_o,
    // Answer side
    input  wire logic       ack_i,
    input  wire pcfg_word_t rdata_i
);
    // Idle bus at time zero
    initial
    begin
        req_o   = 1'b0;
        dir_o   = PCFG_RD;
        dword_o = 6'h00;
        be_n_o  = 4'hF;
        wdata_o = 32'h0;
    end

    // One access, request pulse driven off the falling edge
    task automatic cfg(input pcfg_dir_t d, input logic [5:0] dw,
                       input pcfg_be_t be, input pcfg_word_t wd,
                       output pcfg_word_t rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 32'h0;
        @(negedge clk_i);
        req_o   = 1'b1;
        dir_o   = d;
        dword_o = dw;
        be_n_o  = be;
        wdata_o = wd;
        @(negedge clk_i);
        // Released lines carry junk so stale values cannot pass
        req_o   = 1'b0;
        dir_o   = pcfg_dir_t'(~d);
        dword_o = ~dw;
        be_n_o  = ~be;
        wdata_o = ~wd;
        // Bounded wait, the answer is due within a cycle
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (ack_i === 1'b1)
            begin
                ok = 1'b1;
                rd = rdata_i;
            end
            else
                @(negedge clk_i);
        end
    endtask : cfg
endmodule : pcfg_host

// ---- tb/pcfg_target_tb.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Self-checking bench for the configuration space
// ****************************************************************
module pcfg_target_tb;
    import pcfg_pkg::*;
    // Identity values, arbitrary
    localparam logic [15:0] VEN_CODE  = 16'h5A5A;
    localparam logic [15:0] DEV_CODE  = 16'h0101;
    localparam logic [7:0]  CHIP_STEP = 8'h00;
    // Bench signals
    logic        clk, rst_n, req, ack, addr_perr, data_perr, io_cyc;
    logic        pal_hit, pal_wr, serr_n, serr_oe_n, perr_n, perr_oe_n;
    logic        io_claim, io_abort, pal_upd, mem_en, rom_en;
    logic [5:0]  dword;
    logic [7:0]  mem_base;
    logic [13:0] rom_base;
    pcfg_dir_t   dir;
    pcfg_be_t    be_n, io_be_n;
    pcfg_word_t  wdata, rdata, rd_v;
    int          error_cnt, n_tests, ns, np;

    // 20 MHz clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    pcfg_target #(.VENDOR_CODE(VEN_CODE), .DEVICE_CODE(DEV_CODE),
                  .REV_CODE(CHIP_STEP)) pcfg_target_inst (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CFG_REQ_I(req),
        .CFG_DIR_I(dir), .CFG_DWORD_I(dword), .CFG_BE_N_I(be_n),
        .CFG_WDATA_I(wdata), .CFG_ACK_O(ack), .CFG_RDATA_O(rdata),
        .ADDR_PERR_I(addr_perr), .DATA_PERR_I(data_perr),
        .IO_CYCLE_I(io_cyc), .IO_BE_N_I(io_be_n), .PAL_HIT_I(pal_hit),
        .PAL_WRITE_I(pal_wr), .SERR_N_O(serr_n), .SERR_OE_N_O(serr_oe_n),
        .PERR_N_O(perr_n), .PERR_OE_N_O(perr_oe_n),
        .IO_CLAIM_O(io_claim), .IO_TGT_ABORT_O(io_abort),
        .PAL_UPDATE_O(pal_upd), .MEM_DECODE_EN_O(mem_en),
        .MEM_BASE_O(mem_base), .ROM_BASE_O(rom_base), .ROM_EN_O(rom_en));

    pcfg_host pcfg_host_inst (
        .clk_i(clk), .req_o(req), .dir_o(dir), .dword_o(dword),
        .be_n_o(be_n), .wdata_o(wdata), .ack_i(ack), .rdata_i(rdata));

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
        logic ok;
        pcfg_host_inst.cfg(PCFG_RD, dw, 4'h0, 32'h0, rd_v, ok);
        chk(32'(ok), 32'h1);
        chk(rd_v, exp);
    endtask : rd

    task automatic wr(input logic [5:0] dw, input pcfg_be_t b,
                      input pcfg_word_t d);
        logic ok;
        pcfg_host_inst.cfg(PCFG_WR, dw, b, d, rd_v, ok);
        chk(32'(ok), 32'h1);
    endtask : wr

    // Present an I/O cycle, let the decode settle
    task automatic io(input logic c, input pcfg_be_t b, input logic h,
                      input logic w);
        @(negedge clk);
        io_cyc  = c;
        io_be_n = b;
        pal_hit = h;
        pal_wr  = w;
        #1;
    endtask : io

    // One parity event, count error pin pulses over three cycles
    task automatic err(input logic a, input logic d);
        int k;
        ns = 0;
        np = 0;
        @(negedge clk);
        addr_perr = a;
        data_perr = d;
        for (k = 0; k < 3; k++)
        begin
            @(negedge clk);
            addr_perr = 1'b0;
            data_perr = 1'b0;
            ns += int'(serr_oe_n === 1'b0);
            np += int'(perr_oe_n === 1'b0);
        end
    endtask : err

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_ro();
        rd(6'h00, {DEV_CODE, VEN_CODE});
        rd(6'h01, 32'h0200_0080);
        rd(6'h02, {8'h03, 8'h00, 8'h00, CHIP_STEP});
        chk(32'(mem_en), 32'h0);
        io(1'b1, 4'hC, 1'b0, 1'b0);
        chk(32'(io_claim), 32'h0);
        io(1'b0, 4'hF, 1'b0, 1'b0);
        wr(6'h00, 4'h0, 32'hFFFF_FFFF);
        wr(6'h03, 4'h0, 32'hFFFF_FFFF);
        wr(6'h05, 4'h0, 32'hFFFF_FFFF);
        rd(6'h00, {DEV_CODE, VEN_CODE});
        rd(6'h03, 32'h0);
        rd(6'h05, 32'h0);
        $display("t_reset_ro done");
    endtask : t_reset_ro

    task automatic t_ctrl_io();
        wr(6'h01, 4'hC, 32'h0000_FFFF);
        rd(6'h01, 32'h0200_01E3);
        chk(32'(mem_en), 32'h1);
        io(1'b1, 4'hC, 1'b1, 1'b0);
        chk(32'({io_claim, pal_upd}), 32'h0);
        io(1'b1, 4'hC, 1'b1, 1'b1);
        chk(32'({io_claim, pal_upd}), 32'h1);
        io(1'b1, 4'hC, 1'b0, 1'b0);
        chk(32'({io_claim, io_abort}), 32'h2);
        io(1'b1, 4'hA, 1'b0, 1'b0);
        chk(32'(io_abort), 32'h1);
        io(1'b0, 4'hF, 1'b0, 1'b0);
        rd(6'h01, 32'h0A00_01E3);
        wr(6'h01, 4'h3, 32'h0);
        rd(6'h01, 32'h0A00_01E3);
        wr(6'h01, 4'h3, 32'h0800_0000);
        rd(6'h01, 32'h0200_01E3);
        wr(6'h01, 4'hC, 32'h0000_0001);
        io(1'b1, 4'hC, 1'b1, 1'b0);
        chk(32'(io_claim), 32'h1);
        wr(6'h01, 4'hC, 32'h0);
        io(1'b1, 4'hA, 1'b0, 1'b0);
        chk(32'({io_claim, io_abort}), 32'h0);
        io(1'b0, 4'hF, 1'b0, 1'b0);
        rd(6'h01, 32'h0200_0080);
        $display("t_ctrl_io done");
    endtask : t_ctrl_io

    task automatic t_parity();
        wr(6'h01, 4'hC, 32'h0000_0140);
        err(1'b1, 1'b0);
        chk(32'(ns), 32'h1);
        chk(32'({serr_n, perr_n}), 32'h0);
        rd(6'h01, 32'hCA00_01C0);
        wr(6'h01, 4'h3, 32'hFFFF_0000);
        rd(6'h01, 32'h0200_01C0);
        err(1'b0, 1'b1);
        chk({ns[15:0], np[15:0]}, 32'h0000_0001);
        rd(6'h01, 32'h8A00_01C0);
        wr(6'h01, 4'h0, 32'hFFFF_0100);
        err(1'b1, 1'b0);
        chk(32'(ns), 32'h0);
        rd(6'h01, 32'h8A00_0180);
        err(1'b0, 1'b1);
        chk(32'(np), 32'h0);
        wr(6'h01, 4'h3, 32'hFFFF_0000);
        rd(6'h01, 32'h0200_0180);
        $display("t_parity done");
    endtask : t_parity

    task automatic t_bases();
        wr(6'h04, 4'h0, 32'hFFFF_FFFF);
        rd(6'h04, 32'hFF00_0000);
        chk(32'(mem_base), 32'hFF);
        wr(6'h04, 4'h7, 32'h1200_0000);
        rd(6'h04, 32'h1200_0000);
        wr(6'h0C, 4'h0, 32'hFFFF_FFFF);
        rd(6'h0C, 32'hFFFC_0001);
        chk(32'({rom_base, rom_en}), 32'h7FFE);
        wr(6'h01, 4'hC, 32'h0000_0002);
        chk(32'(rom_en), 32'h1);
        $display("t_bases done");
    endtask : t_bases

    // Watchdog, far beyond the few microseconds the tests need
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        error_cnt = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        addr_perr = 1'b0;
        data_perr = 1'b0;
        io_cyc    = 1'b0;
        io_be_n   = 4'hF;
        pal_hit   = 1'b0;
        pal_wr    = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset_ro();
        t_ctrl_io();
        t_parity();
        t_bases();
        end_sim();
    end
endmodule : pcfg_target_tb
